// [hw/bcda_core.v]
// bcd add datapath with error, equals and carry flags
`timescale 1ns/1ps
`include "bcda_defines.vh"

// Function
// - code 404 adds two 4-digit bcd words into the result word
// - code 405 adds two 8-digit bcd word pairs into a result pair
// - code 406 adds two bcd words plus the carry flag
// - code 407 adds two 8-digit bcd pairs plus the carry flag
// - single ops use one 16-bit word; operands may be constants
// - double ops: first word holds low digits, next word high digits
// - single ops set error when any operand digit is not bcd
// - double ops set error when any digit of either pair is not bcd
// - equals set when the whole result is zero, else cleared
// - carry set on carry out of the top digit, else cleared

module bcda_core #(
  parameter WORD_W = `BCDA_WORD_W
) (
  // clock and control
  input wire SYS_CLK,
  input wire RESET,
  input wire CLK_EN,
  // request from the sequencer
  input wire OP_VALID,
  input wire [11:0] OP_CODE,
  input wire [WORD_W-1:0] AUGEND_LO,
  input wire [WORD_W-1:0] AUGEND_HI,
  input wire [WORD_W-1:0] ADDEND_LO,
  input wire [WORD_W-1:0] ADDEND_HI,
  // result words
  output reg [WORD_W-1:0] RESULT_LO,
  output reg [WORD_W-1:0] RESULT_HI,
  output reg RESULT_WE_LO,
  output reg RESULT_WE_HI,
  output reg DONE,
  // condition flags
  output reg ERROR_FLAG,
  output reg EQUALS_FLAG,
  output reg CARRY_FLAG
);

  localparam DIG = `BCDA_DIGITS_DOUBLE;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire op_single = (OP_CODE == `BCDA_OP_ADD_SINGLE) |
                   (OP_CODE == `BCDA_OP_ADDC_SINGLE);
  wire op_double = (OP_CODE == `BCDA_OP_ADD_DOUBLE) |
                   (OP_CODE == `BCDA_OP_ADDC_DOUBLE);
  wire op_use_cy = (OP_CODE == `BCDA_OP_ADDC_SINGLE) |
                   (OP_CODE == `BCDA_OP_ADDC_DOUBLE);
  wire op_clc = (OP_CODE == `BCDA_OP_CLEAR_CARRY);
  wire op_add = op_single | op_double;

  // high words of single ops are masked so they neither add nor error
  wire [WORD_W-1:0] aug_hi = op_double ? AUGEND_HI : {WORD_W{1'b0}};
  wire [WORD_W-1:0] add_hi = op_double ? ADDEND_HI : {WORD_W{1'b0}};
  wire [4*DIG-1:0] aug = {aug_hi, AUGEND_LO};
  wire [4*DIG-1:0] add = {add_hi, ADDEND_LO};

  // ----------------------------------------------------------------------
  // validity check of both operands
  // ----------------------------------------------------------------------
  wire aug_bad;
  wire add_bad;

  bcda_digit_check #(
    .DIGITS(DIG)
  ) u_chk_aug (
    .word(aug),
    .bad(aug_bad)
  );

  bcda_digit_check #(
    .DIGITS(DIG)
  ) u_chk_add (
    .word(add),
    .bad(add_bad)
  );

  wire operand_bad = aug_bad | add_bad;

  // ----------------------------------------------------------------------
  // ripple of digit adders
  // ----------------------------------------------------------------------
  // eight digits ripple in one cycle; at 50 MHz this path is short enough
  wire [DIG:0] carry_chain;
  wire [4*DIG-1:0] sum;

  assign carry_chain[0] = op_use_cy & CARRY_FLAG;

  genvar d;
  generate
    for (d = 0; d < DIG; d = d + 1) begin : g_add
      bcda_digit_add u_dig (
        .a(aug[4*d+3:4*d]),
        .b(add[4*d+3:4*d]),
        .cin(carry_chain[d]),
        .sum(sum[4*d+3:4*d]),
        .cout(carry_chain[d+1])
      );
    end
  endgenerate

  // carry out taken at digit four or eight by width
  wire carry_out = op_double ? carry_chain[DIG] :
                   carry_chain[`BCDA_DIGITS_SINGLE];
  wire [WORD_W-1:0] sum_hi = op_double ? sum[4*DIG-1:WORD_W] :
                             {WORD_W{1'b0}};
  wire sum_zero = ~|{sum_hi, sum[WORD_W-1:0]};

  // ----------------------------------------------------------------------
  // result and flag registers
  // ----------------------------------------------------------------------
  // every output is a flop; writes take effect the edge after the request
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      RESULT_LO <= {WORD_W{1'b0}};
      RESULT_HI <= {WORD_W{1'b0}};
      RESULT_WE_LO <= 1'b0;
      RESULT_WE_HI <= 1'b0;
      DONE <= 1'b0;
      ERROR_FLAG <= `BCDA_FLAG_RST;
      EQUALS_FLAG <= `BCDA_FLAG_RST;
      CARRY_FLAG <= `BCDA_FLAG_RST;
    end else if (CLK_EN) begin
      RESULT_WE_LO <= 1'b0;
      RESULT_WE_HI <= 1'b0;
      DONE <= 1'b0;
      if (OP_VALID && op_clc) begin
        CARRY_FLAG <= 1'b0;
        DONE <= 1'b1;
      end else if (OP_VALID && op_add) begin
        DONE <= 1'b1;
        ERROR_FLAG <= operand_bad;
        if (operand_bad) begin
          // bad digits: no write, other flags keep their value
          RESULT_WE_LO <= 1'b0;
        end else begin
          RESULT_LO <= sum[WORD_W-1:0];
          RESULT_WE_LO <= 1'b1;
          RESULT_HI <= sum_hi;
          RESULT_WE_HI <= op_double;
          EQUALS_FLAG <= sum_zero;
          CARRY_FLAG <= carry_out;
        end
      end
    end
  end

endmodule

// [hw/bcda_digit_add.v]
// one decimal digit adder with carry in and out
`timescale 1ns/1ps
`include "bcda_defines.vh"

module bcda_digit_add (
  // operands
  input wire [3:0] a,
  input wire [3:0] b,
  input wire cin,
  // answer
  output reg [3:0] sum,
  output reg cout
);

  reg [4:0] raw;
  reg [4:0] adj;

  // binary sum, then add six when it leaves the decimal range
  always @* begin
    raw = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    adj = raw + `BCDA_DIGIT_ADJ;
    if (raw > {1'b0, `BCDA_MAX_DIGIT}) begin
      sum = adj[3:0];  // wraps past ten by design
      cout = 1'b1;
    end else begin
      sum = raw[3:0];
      cout = 1'b0;
    end
  end

endmodule

// [hw/bcda_digit_check.v]
// flags any nibble of a word that is not a decimal digit
`timescale 1ns/1ps
`include "bcda_defines.vh"

module bcda_digit_check #(
  parameter DIGITS = 8
) (
  // word to inspect
  input wire [4*DIGITS-1:0] word,
  // answer
  output wire bad
);

  wire [DIGITS-1:0] bad_digit;

  // ----------------------------------------------------------------------
  // per digit range test
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < DIGITS; i = i + 1) begin : g_dig
      assign bad_digit[i] = word[4*i+3:4*i] > `BCDA_MAX_DIGIT;
    end
  endgenerate

  assign bad = |bad_digit;

endmodule

// [inc/bcda_defines.vh]
// constants for the bcd adder datapath
`ifndef BCDA_DEFINES_VH
`define BCDA_DEFINES_VH

// ----------------------------------------------------------------------
// function codes (three octal-looking digits held as 12-bit bcd)
// ----------------------------------------------------------------------
`define BCDA_OP_ADD_SINGLE 12'h404
`define BCDA_OP_ADD_DOUBLE 12'h405
`define BCDA_OP_ADDC_SINGLE 12'h406
`define BCDA_OP_ADDC_DOUBLE 12'h407
`define BCDA_OP_CLEAR_CARRY 12'h041

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define BCDA_WORD_W 16
`define BCDA_DIGITS_SINGLE 4
`define BCDA_DIGITS_DOUBLE 8
`define BCDA_RESULT_RST 32'h0000_0000
`define BCDA_FLAG_RST 1'b0
`define BCDA_MAX_DIGIT 4'h9
`define BCDA_DIGIT_ADJ 5'h06

`endif

// [verif/bcda_core_bench.sv]
// self-checking bench for the bcd add datapath
`timescale 1ns/1ps
module bcda_core_bench;
  logic clk, rst, en, vld, done, er, eq, cy, we_lo, we_hi;
  logic [11:0] code;
  logic [31:0] au, ad;
  logic [15:0] r_lo, r_hi;
  int n_fail = 0, tests_run = 0;
  bcda_core bcda_core_inst (.SYS_CLK(clk), .RESET(rst), .CLK_EN(en),
    .OP_VALID(vld), .OP_CODE(code), .AUGEND_LO(au[15:0]),
    .AUGEND_HI(au[31:16]), .ADDEND_LO(ad[15:0]), .ADDEND_HI(ad[31:16]),
    .RESULT_LO(r_lo), .RESULT_HI(r_hi), .RESULT_WE_LO(we_lo),
    .RESULT_WE_HI(we_hi), .DONE(done), .ERROR_FLAG(er),
    .EQUALS_FLAG(eq), .CARRY_FLAG(cy));
  bcda_seq_model bcda_seq_model_inst (.clk(clk), .we_lo(we_lo),
    .we_hi(we_hi), .r_lo(r_lo), .r_hi(r_hi), .vld(vld), .code(code),
    .au(au), .ad(ad));
  task automatic chk(input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // f is {done, error, equals, carry}; r is the stored result pair
  task automatic op(input logic [11:0] c, input logic [31:0] a, b, r,
      input logic [3:0] f);
    bcda_seq_model_inst.issue(c, a, b);
    chk({done, er, eq, cy}, f);
    @(posedge clk);
    #1 chk(bcda_seq_model_inst.res, r);
  endtask
  task automatic t_single;
    op(12'h404, 32'h1999, 32'h1, 32'h2000, 4'h8);
    op(12'h404, 32'h9999, 32'h1, 32'h0, 4'hb);
    op(12'h404, 32'hffff_0001, 32'h2, 32'h3, 4'h8);
  endtask
  task automatic t_carry;
    op(12'h404, 32'h9999, 32'h1, 32'h0, 4'hb);
    op(12'h041, 32'h0, 32'h0, 32'h0, 4'ha);
    op(12'h406, 32'h5, 32'h4, 32'h9, 4'h8);
    op(12'h404, 32'h9999, 32'h1, 32'h0, 4'hb);
    op(12'h406, 32'h5, 32'h4, 32'h10, 4'h8);
  endtask
  task automatic t_double;
    op(12'h405, 32'h9999, 32'h1, 32'h0001_0000, 4'h8);
    op(12'h405, 32'h9999_9999, 32'h1, 32'h0, 4'hb);
    op(12'h407, 32'h1234_5678, 32'h1111_1111, 32'h2345_6790, 4'h8);
  endtask
  task automatic t_error;
    op(12'h404, 32'h00a0, 32'h1, 32'h2345_6790, 4'hc);
    op(12'h405, 32'h1, 32'ha000_0000, 32'h2345_6790, 4'hc);
  endtask
  // unknown code and a frozen clock enable both leave everything alone
  task automatic t_refuse;
    op(12'h400, 32'h1, 32'h1, 32'h2345_6790, 4'h4);
    en = 0;
    op(12'h404, 32'h1, 32'h1, 32'h2345_6790, 4'h4);
    en = 1;
    op(12'h404, 32'h1, 32'h1, 32'h2345_0002, 4'h8);
  endtask
  // a reset in mid-run clears every output; the next request is taken
  task automatic t_reset;
    rst = 1;
    @(posedge clk);
    #1 rst = 0;
    chk({r_hi, r_lo}, 32'h0);
    chk({done, er, eq, cy}, 32'h0);
    op(12'h406, 32'h3, 32'h4, 32'h2345_0007, 4'h8);
  endtask
  task automatic stop_test;
    $display("mismatches %0d of %0d checks", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst = 1;
    en = 1;
    repeat (8) @(posedge clk);
    #1 rst = 0;
    t_single();
    t_carry();
    t_double();
    t_error();
    t_refuse();
    t_reset();
    stop_test();
  end
  // about 60 cycles of work; a hang is cut off well after that
  initial begin
    #20000;
    n_fail++;
    stop_test();
  end
endmodule

// [verif/bcda_core_properties.sv]
// assertion checker for the bcd add datapath
`timescale 1ns/1ps
module bcda_core_properties (
  // clock, control and request
  input logic SYS_CLK, RESET, CLK_EN, OP_VALID,
  input logic [11:0] OP_CODE,
  // results and flags
  input logic [15:0] RESULT_LO, RESULT_HI,
  input logic RESULT_WE_LO, RESULT_WE_HI, DONE,
  input logic ERROR_FLAG, EQUALS_FLAG, CARRY_FLAG
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // taken request; codes 404 to 407 share the upper ten bits
  wire tk = CLK_EN && OP_VALID;
  wire add = OP_CODE[11:2] == 10'h101;
  wire [31:0] r = {RESULT_HI, RESULT_LO};
  function automatic bit is_bcd(logic [31:0] v);
    for (int i = 0; i < 8; i++) if (v[4*i+:4] > 4'h9) return 0;
    return 1;
  endfunction
  a_add_done: assert property (tk && add |=> DONE)
    else $error("add not acknowledged");
  a_refuse_other: assert property (tk && !add && OP_CODE != 12'h041 |=> !DONE)
    else $error("unknown code acknowledged");
  a_clear_carry: assert property (tk && OP_CODE == 12'h041 |=> DONE && !CARRY_FLAG)
    else $error("carry not cleared");
  a_write_if_valid: assert property (tk && add |=> RESULT_WE_LO == !ERROR_FLAG)
    else $error("low write disagrees with error");
  a_pair_write: assert property (tk && add |=>
    RESULT_WE_HI == ($past(OP_CODE[0]) && !ERROR_FLAG))
    else $error("high write wrong");
  a_error_no_write: assert property (DONE && ERROR_FLAG |-> !RESULT_WE_LO && !RESULT_WE_HI)
    else $error("write despite error");
  a_hold_result: assert property ($changed(r) && !$past(RESET) |->
    RESULT_WE_LO)
    else $error("result moved without write");
  a_equals_zero: assert property (RESULT_WE_LO |-> EQUALS_FLAG == (r == 0))
    else $error("equals flag wrong");
  a_digits_valid: assert property (RESULT_WE_LO |-> is_bcd(r))
    else $error("result digit not decimal");
  c_double: cover property (tk && OP_CODE == 12'h405);
  c_error: cover property (DONE && ERROR_FLAG);
  c_carry: cover property (CARRY_FLAG && RESULT_WE_HI);
endmodule
bind bcda_core bcda_core_properties bcda_core_properties_inst (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .CLK_EN(CLK_EN), .OP_VALID(OP_VALID),
  .OP_CODE(OP_CODE), .RESULT_LO(RESULT_LO), .RESULT_HI(RESULT_HI),
  .RESULT_WE_LO(RESULT_WE_LO), .RESULT_WE_HI(RESULT_WE_HI), .DONE(DONE),
  .ERROR_FLAG(ERROR_FLAG), .EQUALS_FLAG(EQUALS_FLAG),
  .CARRY_FLAG(CARRY_FLAG));

// [verif/bcda_seq_model.sv]
// sequencer and operand memory model facing the datapath
`timescale 1ns/1ps
module bcda_seq_model (
  input logic clk, we_lo, we_hi,
  input logic [15:0] r_lo, r_hi,
  output logic vld,
  output logic [11:0] code,
  output logic [31:0] au, ad
);
  logic [31:0] res = 32'h0;
  initial begin
    vld = 0; code = 0; au = 0; ad = 0;
  end
  // result pair lands in memory only on the write strobes
  always @(posedge clk) begin
    if (we_lo) res[15:0] <= r_lo;
    if (we_hi) res[31:16] <= r_hi;
  end
  // one request per call; operands inverted after so stale data shows
  task automatic issue(input logic [11:0] c, input logic [31:0] a, b);
    @(posedge clk);
    #1 vld = 1;
    code = c; au = a; ad = b;
    @(posedge clk);
    #1 vld = 0;
    au = ~a; ad = ~b;
  endtask
endmodule
